/* inc/ieb_pkg.sv */
// Constants and types shared by the interrupt enable bank design.
package ieb_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int BANKS      = 4;
	localparam int BANK_W     = 16;
	localparam int SRC_W      = 64;
	localparam int PRIO_W     = 3;
	localparam int PRIO_WORDS = 16;
	localparam int FIELDS     = 4;
	localparam int FIELD_W    = 4;
	localparam int WIDX_W     = 4;
	localparam int SRC_IDX_W  = 6;

	// ****************************************************************
	// Bank layout, bank 1 in the low sixteen bits
	// ****************************************************************
	localparam logic [SRC_W-1:0]  IMPL_MASK  = 64'h010e_4006_22e3_fe1f;
	localparam logic [SRC_W-1:0]  EN_RESET   = 64'h0000_0000_0000_0000;
	localparam logic [SRC_W-1:0]  FLAG_RESET = 64'h0000_0000_0000_0000;
	localparam logic [BANK_W-1:0] PRIO_RESET = 16'h4444;
	localparam logic [BANK_W-1:0] PRIO_WMASK = 16'h7777;

	// ****************************************************************
	// Register map, byte addresses
	// ****************************************************************
	localparam int         ADDR_W         = 8;
	localparam logic [7:0] OFF_EN_BASE    = 8'h00;
	localparam logic [7:0] OFF_FLAG_BASE  = 8'h10;
	localparam logic [7:0] OFF_STATUS     = 8'h20;
	localparam logic [7:0] OFF_PRIO_BASE  = 8'h40;
	localparam logic [7:0] BANK_SPAN_MASK = 8'hf3;
	localparam logic [7:0] PRIO_SPAN_MASK = 8'hc3;

	// ****************************************************************
	// Bus encodings
	// ****************************************************************
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	typedef enum logic [1:0] {
		PH_IDLE   = 2'h0,
		PH_RDWAIT = 2'h1,
		PH_RDDATA = 2'h3
	} ieb_phase_t;

endpackage : ieb_pkg

/* inc/ieb_prio_if.sv */
// Connection between the register front end, the priority store and the scanner.
`timescale 1ns/1ns
interface ieb_prio_if;
	logic                       we;
	logic [ieb_pkg::WIDX_W-1:0] waddr;
	logic [ieb_pkg::BANK_W-1:0] wdata;
	logic [ieb_pkg::WIDX_W-1:0] bus_raddr;
	logic [ieb_pkg::BANK_W-1:0] bus_rdata;
	logic [ieb_pkg::WIDX_W-1:0] scan_raddr;
	logic [ieb_pkg::BANK_W-1:0] scan_rdata;

	modport mem  (input we, waddr, wdata, bus_raddr, scan_raddr, output bus_rdata, scan_rdata);
	modport bus  (output we, waddr, wdata, bus_raddr, input bus_rdata);
	modport scan (output scan_raddr, input scan_rdata);
endinterface : ieb_prio_if

/* hdl/ieb_prio_mem.sv */
// Priority field store: sixteen words, one write port and two registered read ports.
`timescale 1ns/1ns
module ieb_prio_mem (
	input wire logic hclk,
	input wire logic hresetn,
	ieb_prio_if.mem  mp
);
	localparam int WIDX_W = ieb_pkg::WIDX_W;

	logic [ieb_pkg::BANK_W-1:0] word [ieb_pkg::PRIO_WORDS];

	// ****************************************************************
	// Storage, each field resets to the middle priority
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < ieb_pkg::PRIO_WORDS; gi++) begin : g_word
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					word[gi] <= ieb_pkg::PRIO_RESET;
				end else if (mp.we && (mp.waddr == WIDX_W'(gi))) begin
					word[gi] <= mp.wdata & ieb_pkg::PRIO_WMASK;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Read ports
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mp.bus_rdata  <= ieb_pkg::PRIO_RESET;
			mp.scan_rdata <= ieb_pkg::PRIO_RESET;
		end else begin
			mp.bus_rdata  <= word[mp.bus_raddr];
			mp.scan_rdata <= word[mp.scan_raddr];
		end
	end
endmodule : ieb_prio_mem

/* hdl/ieb_arbiter.sv */
// Sweeping arbiter that picks the highest-priority pending source.
`timescale 1ns/1ns
module ieb_arbiter (
	input  wire logic                          hclk,
	input  wire logic                          hresetn,
	input  wire logic [ieb_pkg::SRC_W-1:0]     pending,
	ieb_prio_if.scan                           mp,
	output logic                               irq_valid,
	output logic [ieb_pkg::PRIO_W-1:0]         irq_level,
	output logic [ieb_pkg::SRC_IDX_W-1:0]      irq_source
);
	localparam logic [ieb_pkg::WIDX_W-1:0] LAST_WORD = 4'hf;

	logic [ieb_pkg::WIDX_W-1:0]    scan_cnt;
	logic [ieb_pkg::WIDX_W-1:0]    rd_idx;
	logic                          rd_ok;
	logic [ieb_pkg::PRIO_W-1:0]    acc_lvl;
	logic [ieb_pkg::SRC_IDX_W-1:0] acc_id;
	logic [ieb_pkg::PRIO_W-1:0]    next_lvl;
	logic [ieb_pkg::SRC_IDX_W-1:0] next_id;

	assign mp.scan_raddr = scan_cnt;

	// ****************************************************************
	// Candidate selection over one word
	// ****************************************************************
	// level zero
	// A zero field never wins; ties go to the lower source number.
	always_comb begin
		logic [ieb_pkg::PRIO_W-1:0]    lvl;
		logic [ieb_pkg::SRC_IDX_W-1:0] id;
		lvl      = '0;
		id       = '0;
		next_lvl = acc_lvl;
		next_id  = acc_id;
		for (int j = 0; j < ieb_pkg::FIELDS; j++) begin
			lvl = mp.scan_rdata[j*ieb_pkg::FIELD_W +: ieb_pkg::PRIO_W];
			id  = {rd_idx, j[1:0]};
			if (rd_ok && pending[id] && (lvl != '0) && (lvl > next_lvl)) begin
				next_lvl = lvl;
				next_id  = id;
			end
		end
	end

	// ****************************************************************
	// Sweep and result
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scan_cnt <= '0;
			rd_idx   <= '0;
			rd_ok    <= 1'b0;
		end else begin
			scan_cnt <= scan_cnt + 4'h1;
			rd_idx   <= scan_cnt;
			rd_ok    <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_lvl    <= '0;
			acc_id     <= '0;
			irq_valid  <= 1'b0;
			irq_level  <= '0;
			irq_source <= '0;
		end else if (rd_ok && (rd_idx == LAST_WORD)) begin
			acc_lvl    <= '0;
			acc_id     <= '0;
			// A source that stopped pending mid-sweep must not be published from its stale level.
			irq_valid  <= (next_lvl != '0) && pending[next_id];
			irq_level  <= next_lvl;
			irq_source <= next_id;
		end else begin
			acc_lvl <= next_lvl;
			acc_id  <= next_id;
			// A request withdrawn mid-sweep is dropped at once.
			if (!pending[irq_source]) begin
				irq_valid <= 1'b0;
			end
		end
	end
endmodule : ieb_arbiter

/* hdl/ieb_top.sv */
// Interrupt enable bank with flag, priority and arbitration, reached over AHB-Lite.
`timescale 1ns/1ns
module ieb_top (
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic                           hresp,
	output logic [31:0]                    hrdata,
	input  wire logic [ieb_pkg::SRC_W-1:0] irq_event,
	output logic [ieb_pkg::SRC_W-1:0]      int_enable,
	output logic [ieb_pkg::SRC_W-1:0]      int_flag,
	output logic                           irq_valid,
	output logic [ieb_pkg::PRIO_W-1:0]     irq_level,
	output logic [ieb_pkg::SRC_IDX_W-1:0]  irq_source
);

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function automatic logic in_span(input logic [7:0] a, input logic [7:0] base, input logic [7:0] span);
		in_span = ((a & span) == base);
	endfunction : in_span

	ieb_pkg::ieb_phase_t        phase;
	ieb_pkg::ieb_phase_t        next_phase;
	logic [7:0]                 addr_q;
	logic                       hi_ok;
	logic                       wr_pend;
	logic [ieb_pkg::SRC_W-1:0]  next_enable;
	logic [ieb_pkg::SRC_W-1:0]  next_flag;
	logic [ieb_pkg::SRC_W-1:0]  wr_lanes;
	logic [ieb_pkg::SRC_W-1:0]  wr_value;
	logic [ieb_pkg::SRC_W-1:0]  pending;
	logic [31:0]                rd_mux;
	logic [ieb_pkg::BANK_W-1:0] en_word;
	logic [ieb_pkg::BANK_W-1:0] flag_word;

	wire        take     = hsel && htrans[1] && hready;
	wire [1:0]  bank_idx = addr_q[3:2];
	wire        hit_en   = hi_ok && in_span(addr_q, ieb_pkg::OFF_EN_BASE, ieb_pkg::BANK_SPAN_MASK);
	wire        hit_flag = hi_ok && in_span(addr_q, ieb_pkg::OFF_FLAG_BASE, ieb_pkg::BANK_SPAN_MASK);
	wire        hit_prio = hi_ok && in_span(addr_q, ieb_pkg::OFF_PRIO_BASE, ieb_pkg::PRIO_SPAN_MASK);
	wire        hit_stat = hi_ok && (addr_q == ieb_pkg::OFF_STATUS);
	wire        wr_en    = wr_pend && hit_en;
	wire        wr_flag  = wr_pend && hit_flag;

	ieb_prio_if pif ();

	// ****************************************************************
	// Priority store and arbiter
	// ****************************************************************
	assign pif.we        = wr_pend && hit_prio;
	assign pif.waddr     = addr_q[5:2];
	assign pif.wdata     = hwdata[ieb_pkg::BANK_W-1:0];
	assign pif.bus_raddr = addr_q[5:2];

	ieb_prio_mem u_mem (
		.hclk    (hclk),
		.hresetn (hresetn),
		.mp      (pif.mem)
	);

	assign pending = int_flag & int_enable & ieb_pkg::IMPL_MASK;

	ieb_arbiter u_arb (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.pending    (pending),
		.mp         (pif.scan),
		.irq_valid  (irq_valid),
		.irq_level  (irq_level),
		.irq_source (irq_source)
	);

	// ****************************************************************
	// Register write data
	// ****************************************************************
	// The write lands in the lanes of the addressed bank only.
	assign wr_lanes = {{ieb_pkg::BANK_W{bank_idx == 2'h3}}, {ieb_pkg::BANK_W{bank_idx == 2'h2}},
	                   {ieb_pkg::BANK_W{bank_idx == 2'h1}}, {ieb_pkg::BANK_W{bank_idx == 2'h0}}};
	assign wr_value = {ieb_pkg::BANKS{hwdata[ieb_pkg::BANK_W-1:0]}};

	// bit positions
	// The implemented mask fixes every documented enable position per bank.
	assign next_enable = wr_en ? (((int_enable & ~wr_lanes) | (wr_value & wr_lanes)) & ieb_pkg::IMPL_MASK)
	                           : int_enable;

	// flag set
	// An event in the cycle of a software clear wins over that clear.
	assign next_flag = ((wr_flag ? ((int_flag & ~wr_lanes) | (wr_value & wr_lanes)) : int_flag) | irq_event)
	                   & ieb_pkg::IMPL_MASK;

	// ****************************************************************
	// Register state
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_enable <= ieb_pkg::EN_RESET;
			int_flag   <= ieb_pkg::FLAG_RESET;
		end else begin
			int_enable <= next_enable;
			int_flag   <= next_flag;
		end
	end

	// ****************************************************************
	// Read data selection
	// ****************************************************************
	assign en_word   = int_enable[bank_idx*ieb_pkg::BANK_W +: ieb_pkg::BANK_W];
	assign flag_word = int_flag[bank_idx*ieb_pkg::BANK_W +: ieb_pkg::BANK_W];

	assign rd_mux = hit_en   ? {16'h0000, en_word} :
	                hit_flag ? {16'h0000, flag_word} :
	                hit_prio ? {16'h0000, pif.bus_rdata} :
	                hit_stat ? {16'h0000, 6'h00, irq_valid, irq_level, irq_source} :
	                32'h0000_0000;

	// ****************************************************************
	// Bus phases
	// ****************************************************************
	// Reads wait two cycles so the registered priority port has settled,
	// including a read that directly follows a write to the same word.
	always_comb begin
		next_phase = phase;
		unique case (phase)
			ieb_pkg::PH_IDLE: begin
				if (take && !hwrite) begin
					next_phase = ieb_pkg::PH_RDWAIT;
				end
			end
			ieb_pkg::PH_RDWAIT: begin
				next_phase = ieb_pkg::PH_RDDATA;
			end
			ieb_pkg::PH_RDDATA: begin
				next_phase = ieb_pkg::PH_IDLE;
			end
			default: begin
				next_phase = ieb_pkg::PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase <= ieb_pkg::PH_IDLE;
		end else begin
			phase <= next_phase;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q  <= '0;
			hi_ok   <= 1'b0;
			wr_pend <= 1'b0;
		end else begin
			wr_pend <= take && hwrite && (phase == ieb_pkg::PH_IDLE);
			if (take && (phase == ieb_pkg::PH_IDLE)) begin
				addr_q <= haddr[ieb_pkg::ADDR_W-1:0];
				hi_ok  <= (haddr[31:ieb_pkg::ADDR_W] == 24'h00_0000);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
			hresp     <= ieb_pkg::HRESP_OKAY[0];
		end else begin
			hresp     <= ieb_pkg::HRESP_OKAY[0];
			hreadyout <= (next_phase == ieb_pkg::PH_IDLE);
			if (phase == ieb_pkg::PH_RDDATA) begin
				hrdata <= rd_mux;
			end
		end
	end

endmodule : ieb_top

/* verif/ieb_top_properties.sv */
// Concurrent checks on the ports of the interrupt enable bank.
`timescale 1ns/1ns
module ieb_top_properties (
	input wire logic                      hclk,
	input wire logic                      hresetn,
	input wire logic                      hsel,
	input wire logic [31:0]               haddr,
	input wire logic [1:0]                htrans,
	input wire logic                      hwrite,
	input wire logic [31:0]               hwdata,
	input wire logic                      hready,
	input wire logic                      hresp,
	input wire logic [ieb_pkg::SRC_W-1:0] irq_event,
	input wire logic [ieb_pkg::SRC_W-1:0] int_enable,
	input wire logic [ieb_pkg::SRC_W-1:0] int_flag,
	input wire logic                      irq_valid,
	input wire logic [ieb_pkg::PRIO_W-1:0] irq_level,
	input wire logic [ieb_pkg::SRC_IDX_W-1:0] irq_source
);
	logic        wr_pend;
	logic [31:0] wr_addr;

	// Remembers a write address phase so its data phase can be judged.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 32'h0;
		end else begin
			wr_pend <= hsel & htrans[1] & hwrite & hready;
			wr_addr <= haddr;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_unimpl_en_zero: assert property ((int_enable & ~ieb_pkg::IMPL_MASK) == 64'h0)
		else $error("unimplemented enable bit set");
	a_unimpl_flag_zero: assert property ((int_flag & ~ieb_pkg::IMPL_MASK) == 64'h0)
		else $error("unimplemented flag bit set");
	a_flag_on_event: assert property ((|(irq_event & ieb_pkg::IMPL_MASK)) |=>
		(int_flag & $past(irq_event) & ieb_pkg::IMPL_MASK) == ($past(irq_event) & ieb_pkg::IMPL_MASK))
		else $error("event did not set its flag");
	a_bank_one_write: assert property (wr_pend && wr_addr == 32'h0 |=>
		int_enable[15:0] == ($past(hwdata[15:0]) & 16'hfe1f))
		else $error("bank one enable not written as masked");
	a_enable_holds: assert property (!(wr_pend && wr_addr[31:4] == 28'h0) |=> $stable(int_enable))
		else $error("enable changed without a write");
	a_idle_no_irq: assert property ((!(|(int_flag & int_enable)))[*3] |-> !irq_valid)
		else $error("request shown with nothing pending");
	a_level_nonzero: assert property (irq_valid |-> irq_level != 3'h0)
		else $error("request shown at priority zero");
	a_source_real: assert property (irq_valid |-> ieb_pkg::IMPL_MASK[irq_source])
		else $error("winning source is unimplemented");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
endmodule : ieb_top_properties

bind ieb_top ieb_top_properties i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hresp(hresp),
	.irq_event(irq_event), .int_enable(int_enable), .int_flag(int_flag), .irq_valid(irq_valid),
	.irq_level(irq_level), .irq_source(irq_source));

/* verif/tb_ieb_top.sv */
// Self-checking bench for the interrupt enable bank.
`timescale 1ns/1ns
module tb_ieb_top;
	logic        hclk = 1'b0;
	logic        hresetn, hsel, hwrite, hreadyout, hresp, irq_valid, rd_dphase;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize, irq_level;
	logic [63:0] irq_event, int_enable, int_flag;
	logic [5:0]  irq_source;
	logic [31:0] expq[$];
	logic [15:0] bank_mask [4] = '{16'hfe1f, 16'h22e3, 16'h4006, 16'h010e};
	int          miscompares = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          seed = 32'hf67f28fd;

	always #10 hclk = ~hclk;

	ieb_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .irq_event(irq_event), .int_enable(int_enable),
		.int_flag(int_flag), .irq_valid(irq_valid), .irq_level(irq_level), .irq_source(irq_source));

	task check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	// One single transfer; a read notes its expected word for the monitor.
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		if (!w) begin
			expq.push_back(e);
			rd_dphase <= 1'b1;
		end
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd_dphase <= 1'b0;
	endtask : xfer

	task wait_irq(input logic v);
		int n;
		n = 0;
		while (irq_valid !== v && n < 40) begin
			@(posedge hclk);
			n++;
		end
		check(irq_valid, v);
	endtask : wait_irq

	always @(posedge hclk)
		if (rd_dphase === 1'b1 && hreadyout === 1'b1)
			check(hrdata, expq.pop_front());

	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			give_verdict();
		end
	end

	initial begin
		logic [31:0] r;
		{hresetn, hsel, hwrite, rd_dphase, haddr, htrans, hwdata, irq_event} = '0;
		hsize = 3'h2;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		for (int b = 0; b < 4; b++) begin
			xfer(1'b0, 32'(b * 4), 32'h0, 32'h0);
			xfer(1'b0, 32'(b * 4 + 16), 32'h0, 32'h0);
		end
		xfer(1'b0, 32'h40, 32'h0, 32'h4444);
		$display("test reset values done");
		for (int b = 0; b < 4; b++) begin
			xfer(1'b1, 32'(b * 4), 32'hffff_ffff, 32'h0);
			xfer(1'b0, 32'(b * 4), 32'h0, 32'(bank_mask[b]));
			check(int_enable[b * 16 +: 16], bank_mask[b]);
			r = $random(seed);
			xfer(1'b1, 32'(b * 4), r, 32'h0);
			xfer(1'b0, 32'(b * 4), 32'h0, r & 32'(bank_mask[b]));
		end
		$display("test bank layout done");
		xfer(1'b1, 32'h0, 32'h1, 32'h0);
		@(posedge hclk) irq_event <= 64'h1e1;
		@(posedge hclk) irq_event <= 64'h0;
		wait_irq(1'b1);
		check(irq_source, 6'h0);
		check(irq_level, 3'h4);
		xfer(1'b0, 32'h20, 32'h0, 32'h300);
		xfer(1'b1, 32'h40, 32'h4440, 32'h0);
		wait_irq(1'b0);
		xfer(1'b1, 32'h40, 32'h4444, 32'h0);
		wait_irq(1'b1);
		xfer(1'b1, 32'h0, 32'h0, 32'h0);
		wait_irq(1'b0);
		xfer(1'b0, 32'h10, 32'h0, 32'h1);
		$display("test request gating done");
		xfer(1'b1, 32'h100, 32'hffff, 32'h0);
		xfer(1'b1, 32'h30, 32'hffff, 32'h0);
		xfer(1'b0, 32'h30, 32'h0, 32'h0);
		xfer(1'b0, 32'h0, 32'h0, 32'h0);
		$display("test unmapped access done");
		give_verdict();
	end
endmodule : tb_ieb_top
